// *** rvel_pkg.sv ***
// Package for the mask program memory verify read-back path
package rvel_pkg;
  localparam int unsigned CODE_AW_16K   = 14;
  localparam int unsigned CODE_AW_8K    = 13;
  localparam int unsigned ENC_AW        = 6;
  localparam int unsigned ENC_DEPTH     = 64;
  localparam int unsigned SIG_AW        = 2;
  localparam int unsigned SIG_DEPTH     = 4;
  localparam logic [7:0]  ENC_ERASED    = 8'hFF;
  localparam logic [7:0]  LOCKED_BYTE   = 8'hFF;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam int unsigned READ_LATENCY  = 2;

  typedef enum logic [1:0] {
    RVEL_SEL_CODE = 2'b00,
    RVEL_SEL_SIG  = 2'b01
  } rvel_sel_e;

  typedef struct packed {
    logic      valid;
    rvel_sel_e sel;
    logic [13:0] addr;
  } rvel_req_s;

  typedef struct packed {
    logic lock_bit_one;
    logic lock_bit_two;
    logic lock_bit_three;
  } rvel_lock_s;

  typedef enum logic [1:0] {
    RVEL_IDLE  = 2'b00,
    RVEL_FETCH = 2'b01,
    RVEL_DRIVE = 2'b11
  } rvel_state_e;
endpackage : rvel_pkg

// *** rvel_rom.sv ***
// Synchronous read-only arrays: code, encryption and signature
`timescale 1ns/10ps
module rvel_rom #(
  parameter int unsigned CODE_AW = 14,
  parameter logic [7:0]  SIG0    = 8'h11,
  parameter logic [7:0]  SIG1    = 8'h22,
  parameter logic [7:0]  SIG2    = 8'h33,
  parameter logic [7:0]  SIG3    = 8'h44
) (
  // Clock
  input  wire logic                clk_sys,
  // Lookup
  input  wire logic [CODE_AW-1:0]  code_addr,
  input  wire logic [5:0]          enc_addr,
  input  wire logic [1:0]          sig_addr,
  output logic      [7:0]          code_byte,
  output logic      [7:0]          enc_byte,
  output logic      [7:0]          sig_byte
);
  import rvel_pkg::*;

  // Mask contents; ROM arrays are loaded by the mask flow, so code is zero, key erased and signature set here
  logic [7:0] code_mem [0:(1<<CODE_AW)-1];
  logic [7:0] enc_mem  [0:ENC_DEPTH-1];
  logic [7:0] sig_mem  [0:SIG_DEPTH-1];

  // arrays; signature is fixed and has no write path
  initial begin
    for (int i = 0; i < (1 << CODE_AW); i++) begin
      code_mem[i] = 8'h00;
    end
    for (int i = 0; i < ENC_DEPTH; i++) begin
      enc_mem[i] = ENC_ERASED;
    end
    sig_mem[0] = SIG0; // Arbitrary signature values
    sig_mem[1] = SIG1;
    sig_mem[2] = SIG2;
    sig_mem[3] = SIG3;
  end

  always_ff @(posedge clk_sys) begin
    code_byte <= code_mem[code_addr];
    enc_byte  <= enc_mem[enc_addr];
    sig_byte  <= sig_mem[sig_addr];
  end
endmodule : rvel_rom

// *** rvel_verify.sv ***
// Verify read-back path with encryption and lock gating
`timescale 1ns/10ps
module rvel_verify #(
  parameter int unsigned CODE_AW = rvel_pkg::CODE_AW_16K
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // Request from verify pins
  input  wire rvel_pkg::rvel_req_s req_pin,
  // Lock fuses
  input  wire rvel_pkg::rvel_lock_s lock_pin,
  // Answer
  output logic      [7:0]         verify_data,
  output logic                    verify_valid,
  output logic                    verify_locked
);
  import rvel_pkg::*;

  // Pin inputs cross via two flops before use
  rvel_req_s   req_s1_reg, req_s2_reg, req_s1_next, req_s2_next;
  rvel_lock_s  lock_s1_reg, lock_s2_reg, lock_s1_next, lock_s2_next;
  rvel_req_s   req_hold_reg, req_hold_next;
  rvel_state_e state_reg, state_next;
  logic [7:0]  data_reg, data_next;
  logic        valid_reg, valid_next;
  logic        locked_reg, locked_next;
  logic [7:0]  code_byte, enc_byte, sig_byte;

  function automatic logic verify_blocked(input rvel_lock_s l);
    // Only lock bit two gates verify; one and three do nothing here
    return l.lock_bit_two;
  endfunction : verify_blocked

  // Code reads are every select but the signature one
  function automatic logic is_code_read(input rvel_req_s r);
    return r.sel != RVEL_SEL_SIG;
  endfunction : is_code_read

  rvel_rom #(.CODE_AW(CODE_AW)) u_rom (
    .clk_sys   (clk_sys),
    .code_addr (req_hold_reg.addr[CODE_AW-1:0]),
    .enc_addr  (req_hold_reg.addr[ENC_AW-1:0]),
    .sig_addr  (req_hold_reg.addr[SIG_AW-1:0]),
    .code_byte (code_byte),
    .enc_byte  (enc_byte),
    .sig_byte  (sig_byte)
  );

  // Address rides the same two stages as valid; equipment holds it with valid
  always_comb begin
    req_s1_next  = req_pin;
    req_s2_next  = req_s1_reg;
    lock_s1_next = lock_pin;
    lock_s2_next = lock_s1_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_reg  <= '0;
      req_s2_reg  <= '0;
      lock_s1_reg <= '0;
      lock_s2_reg <= '0;
    end else begin
      req_s1_reg  <= req_s1_next;
      req_s2_reg  <= req_s2_next;
      lock_s1_reg <= lock_s1_next;
      lock_s2_reg <= lock_s2_next;
    end
  end

  always_comb begin
    state_next    = state_reg;
    req_hold_next = req_hold_reg;
    data_next     = data_reg;
    valid_next    = 1'b0;
    locked_next   = verify_blocked(lock_s2_reg);
    case (state_reg)
      // Requests arriving while busy are dropped, not queued
      RVEL_IDLE: begin
        if (req_s2_reg.valid) begin
          req_hold_next = req_s2_reg;
          state_next    = RVEL_FETCH;
        end
      end
      RVEL_FETCH: begin
        state_next = RVEL_DRIVE;
      end
      RVEL_DRIVE: begin
        valid_next = 1'b1;
        if (!is_code_read(req_hold_reg)) begin
          data_next = sig_byte;
        end else if (verify_blocked(lock_s2_reg)) begin
          data_next = LOCKED_BYTE;
        end else begin
          // Erased key gives code, all-ones code gives key
          data_next = ~(code_byte ^ enc_byte);
        end
        state_next = RVEL_IDLE;
      end
      default: begin
        state_next = RVEL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= RVEL_IDLE;
      req_hold_reg <= '0;
      data_reg     <= DATA_RST;
      valid_reg    <= 1'b0;
      locked_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      req_hold_reg <= req_hold_next;
      data_reg     <= data_next;
      valid_reg    <= valid_next;
      locked_reg   <= locked_next;
    end
  end

  assign verify_data   = data_reg;
  assign verify_valid  = valid_reg;
  assign verify_locked = locked_reg;

  locked_const_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && req_hold_reg.sel == RVEL_SEL_CODE && lock_s2_reg.lock_bit_two)
    |=> (verify_data == LOCKED_BYTE && verify_valid))
    else $error("Locked verify did not return constant");

  xnor_out_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && req_hold_reg.sel == RVEL_SEL_CODE && !lock_s2_reg.lock_bit_two)
    |=> (verify_data == ~($past(code_byte) ^ $past(enc_byte))))
    else $error("Verify byte is not code xnor key");

  erased_key_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && req_hold_reg.sel == RVEL_SEL_CODE && !lock_s2_reg.lock_bit_two
     && enc_byte == ENC_ERASED) |=> (verify_data == $past(code_byte)))
    else $error("Erased key altered code");

  ones_code_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && req_hold_reg.sel == RVEL_SEL_CODE && !lock_s2_reg.lock_bit_two
     && code_byte == 8'hFF) |=> (verify_data == $past(enc_byte)))
    else $error("All-ones code did not show key");

  sig_read_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && req_hold_reg.sel == RVEL_SEL_SIG) |=> (verify_data == $past(sig_byte)))
    else $error("Signature byte wrong");

  lock_one_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lock_s2_reg.lock_bit_one && !lock_s2_reg.lock_bit_two) |=> !verify_locked)
    else $error("Lock bit one blocked verify");

  answer_time_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_IDLE && req_s2_reg.valid) |-> ##3 verify_valid)
    else $error("Answer latency wrong");

  enc_index_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_FETCH) |-> (req_hold_reg.addr[5:0] == $past(req_s2_reg.addr[5:0])))
    else $error("Key index not from low six address bits");

  // Answer pulse, hold, request-take and lock-level checks
  pulse_once_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    verify_valid
    |=> !verify_valid)
    else $error("Verify valid held longer than one cycle");

  data_stands_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg != RVEL_DRIVE)
    |=> $stable(verify_data))
    else $error("Verify byte changed without an answer");

  no_early_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg != RVEL_DRIVE)
    |=> !verify_valid)
    else $error("Verify valid outside the drive step");

  req_ignored_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg != RVEL_IDLE)
    |=> $stable(req_hold_reg))
    else $error("Held request changed while busy");

  lock_level_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    verify_locked == $past(lock_s2_reg.lock_bit_two))
    else $error("Lock flag does not follow lock bit two");

  lock_three_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lock_s2_reg.lock_bit_three && !lock_s2_reg.lock_bit_two)
    |=> !verify_locked)
    else $error("Lock bit three blocked verify");

  take_idle_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_IDLE && req_s2_reg.valid)
    |=> (state_reg == RVEL_FETCH && req_hold_reg == $past(req_s2_reg)))
    else $error("Idle request not taken");

  level_one_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && is_code_read(req_hold_reg) && lock_s2_reg == '0)
    |=> (verify_valid && verify_data == ~($past(code_byte) ^ $past(enc_byte))))
    else $error("Unlocked verify byte not encrypted");

  lock_one_data_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && is_code_read(req_hold_reg)
     && lock_s2_reg.lock_bit_one && !lock_s2_reg.lock_bit_two)
    |=> (verify_data == ~($past(code_byte) ^ $past(enc_byte))))
    else $error("Lock bit one changed the verify byte");

  sig_unlocked_a : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg == RVEL_DRIVE && !is_code_read(req_hold_reg) && lock_s2_reg.lock_bit_two)
    |=> (verify_valid && verify_data == $past(sig_byte)))
    else $error("Signature read refused by lock");
endmodule : rvel_verify

// *** rvel_prog_model.sv ***
// Model of the external verify equipment
`timescale 1ns/10ps
module rvel_prog_model
  import rvel_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Answer from the device
  input  wire logic [7:0] verify_data,
  input  wire logic       verify_valid,
  // Request to the device
  output rvel_req_s       req_pin
);
  initial req_pin = '0;

  // Request held steady until the answer pulse is sampled
  task automatic rd(input rvel_sel_e s, input logic [13:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    req_pin <= '{valid: 1'b1, sel: s, addr: a};
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_sys);
      if (verify_valid === 1'b1) begin
        ok = 1'b1;
        d  = verify_data;
      end
    end
    // Idle lines wander, so a stale address is never reused
    req_pin <= '{valid: 1'b0, sel: s, addr: ~a};
    // Late retrigger from the synchroniser must die out
    repeat (8) @(posedge clk_sys);
  endtask : rd
endmodule : rvel_prog_model

// *** rom_verify_encryption_lock_bench.sv ***
// Bench for the verify read-back path
`timescale 1ns/10ps
module rom_verify_encryption_lock_bench;
  import rvel_pkg::*;
  localparam logic [31:0] SIGS = 32'h44332211;
  logic       clk_sys     = 1'b0;
  logic       rst_b       = 1'b0;
  rvel_req_s  req_pin;
  rvel_lock_s lock_pin    = '0;
  logic [7:0] verify_data;
  logic       verify_valid;
  logic       verify_locked;
  int         miscompares = 0;
  int         n_checks    = 0;
  int         seed        = 51;

  always #5 clk_sys = ~clk_sys;

  rvel_verify dut (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .req_pin       (req_pin),
    .lock_pin      (lock_pin),
    .verify_data   (verify_data),
    .verify_valid  (verify_valid),
    .verify_locked (verify_locked)
  );

  rvel_prog_model u_prog (
    .clk_sys      (clk_sys),
    .verify_data  (verify_data),
    .verify_valid (verify_valid),
    .req_pin      (req_pin)
  );

  // Expected byte from the lock level and the code and key placed for the read
  function automatic logic [7:0] exp_byte(rvel_sel_e s, logic [1:0] a, logic lk2, logic [7:0] c, logic [7:0] k);
    if (s == RVEL_SEL_SIG) return SIGS[a*8 +: 8];
    if (lk2) return LOCKED_BYTE;
    return ~(c ^ k);
  endfunction : exp_byte

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic print_verdict();
    $display("Checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic rd_chk(input rvel_sel_e s, input logic [13:0] a, input logic [7:0] c, input logic [7:0] k);
    logic [7:0] d;
    bit         ok;
    if (s == RVEL_SEL_CODE) begin
      // Mask image for this read: the given code byte and its key byte
      dut.u_rom.code_mem[a] = c;
      dut.u_rom.enc_mem[a[5:0]] = k;
    end
    u_prog.rd(s, a, d, ok);
    if (!ok) begin
      miscompares++;
      $display("Error verify_valid expected 1 seen 0");
      print_verdict();
    end else chk8("verify_data", exp_byte(s, a[1:0], lock_pin.lock_bit_two, c, k), d);
  endtask : rd_chk

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int l = 0; l < 8; l++) begin
      lock_pin <= rvel_lock_s'(l[2:0]);
      repeat (4) @(posedge clk_sys);
      chk1("verify_locked", lock_pin.lock_bit_two, verify_locked);
      rd_chk(RVEL_SEL_CODE, 14'h0000, 8'($random(seed)), ENC_ERASED);
      rd_chk(RVEL_SEL_CODE, 14'h3FFF, 8'hFF, 8'($random(seed)));
      rd_chk(RVEL_SEL_CODE, 14'h2A15, 8'h5A, 8'hC3);
      for (int s = 0; s < 4; s++) rd_chk(RVEL_SEL_SIG, 14'(s), 8'h00, 8'h00);
      repeat (3) rd_chk(RVEL_SEL_CODE, 14'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk8("verify_data", DATA_RST, verify_data);
    chk1("verify_valid", 1'b0, verify_valid);
    chk1("verify_locked", 1'b0, verify_locked);
    // Second release: lock level must come back through the synchroniser
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk1("verify_locked", lock_pin.lock_bit_two, verify_locked);
    rd_chk(RVEL_SEL_CODE, 14'h0040, 8'h3C, 8'hFF);
    print_verdict();
  end
endmodule : rom_verify_encryption_lock_bench
